// File: verilog/slc_regs.vh
/*
 * Constants of the strap capture block: register byte offsets, field
 * positions, tie-off values and reset values.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef SLC_REGS_VH
`define SLC_REGS_VH

// register byte offsets, one aligned word each
`define SLC_ADDR_W        8
`define SLC_OFF_RESET     8'h00
`define SLC_OFF_EECMD     8'h04
`define SLC_OFF_LEDCFG    8'h08
`define SLC_OFF_PHYCTL    8'h0C
`define SLC_OFF_ADVERT    8'h10
`define SLC_OFF_SPMODE    8'h14
`define SLC_OFF_XOVER     8'h18
`define SLC_OFF_LATCHED   8'h1C
`define SLC_OFF_HARD      8'h20

// reset control and eeprom command fields
`define SLC_RST_DIGITAL   0
`define SLC_CMD_RELOAD    0
`define SLC_CMD_BUSY      1
`define SLC_CMD_OVR       2

// led config fields
`define SLC_LED_SEL_LSB   0
`define SLC_LED_FUNCTION_BITS_LSB   8

// phy control fields
`define SLC_AUTONEG_ENABLE_BIT        0
`define SLC_PHY_SPD       1
`define SLC_PHY_DUP       2

// advertisement fields
`define SLC_ADV_10HD      5
`define SLC_ADV_10FD      6

// crossover fields
`define SLC_XO_OVR        0
`define SLC_XO_AUTO       1
`define SLC_XO_MAN        2

// soft strap vector layout
`define SLC_SV_W          14
`define SLC_SV_LED_SEL    0
`define SLC_SV_LED_FUNCTION_BITS    8
`define SLC_SV_XAUTO      10
`define SLC_SV_XMAN       11
`define SLC_SV_AN         12
`define SLC_SV_SPD        13

// defaults vector layout
`define SLC_DF_W          18
`define SLC_DF_LED_SEL    0
`define SLC_DF_LED_FUNCTION_BITS    8
`define SLC_DF_AN         10
`define SLC_DF_SPD        11
`define SLC_DF_DUP        12
`define SLC_DF_ADV5       13
`define SLC_DF_ADV6       14
`define SLC_DF_MODE       15

// tie-offs for straps without a pin, and the mode code used under autoneg
`define SLC_TIE_XMAN      1'b0
`define SLC_TIE_DUPLEX    1'b1
`define SLC_MODE_AN       3'h7

// storage value while chip reset is held
`define SLC_SV_RESET      14'h0000

`endif

// File: verilog/slc_sync.v
/*
 * Two flip-flop synchroniser for a bundle of strap pin levels.
 * Assumes the inputs are quasi-static pins from outside the clock domain.
 */
`timescale 1ns/1ps

module slc_sync #(
	parameter W = 1
) (
	input  wire         CLK,
	input  wire [W-1:0] D,
	output wire [W-1:0] Q
);

	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	// no reset: pins keep being sampled while chip reset is held
	always @(posedge CLK)
	begin
		meta_q <= D;
		sync_q <= meta_q;
	end

	assign Q = sync_q;

endmodule

// File: verilog/slc_top.v
/*
 * Strap capture and soft strap override block: latches strap pins at
 * release of chip reset, keeps them in private storage, lays loader
 * values over them and presents the resulting configuration registers.
 * Assumes RST_N is the combined power-on and pin reset, already
 * synchronous to CLK, and a loader on the same clock.
 */
`timescale 1ns/1ps
`include "slc_regs.vh"

module slc_top #(
	parameter HARD_W = 4
) (
	input  wire                   CLK,
	input  wire                   RST_N,
	input  wire                   STRAP_LED_SELECT_BITS,
	input  wire [1:0]             STRAP_LED_FUNCTION_BITS,
	input  wire                   STRAP_AUTO_XOVER,
	input  wire                   STRAP_AUTONEG,
	input  wire                   STRAP_SPEED,
	input  wire [HARD_W-1:0]      STRAP_HARD,
	input  wire [`SLC_ADDR_W-1:0] ADDR,
	input  wire [31:0]            WDATA,
	input  wire                   WR,
	input  wire                   RD,
	output reg  [31:0]            RDATA,
	output reg                    LDR_START,
	input  wire                   LDR_DONE,
	input  wire                   LDR_OK,
	input  wire [`SLC_SV_W-1:0]   LDR_DATA,
	output reg                    DIGITAL_RESET,
	output wire [HARD_W-1:0]      HARD_CFG,
	output wire [7:0]             LED_SELECT,
	output wire [1:0]             LED_FUNCTION,
	output wire                   P1_AUTONEG,
	output wire                   P1_SPEED_LOW,
	output wire                   P1_DUPLEX,
	output wire                   P1_ADV_10FD,
	output wire                   P1_ADV_10HD,
	output wire [2:0]             P1_MODE,
	output reg                    P1_XOVER_AUTO,
	output reg                    P1_XOVER_CROSS
);

	wire [5+HARD_W:0]    pins_sync;
	reg                  up_q;
	reg  [`SLC_SV_W-1:0] latched_q;
	reg  [HARD_W-1:0]    hard_q;
	reg  [`SLC_SV_W-1:0] ovr_q;
	reg                  ovr_valid_q;
	reg                  busy_q;
	reg  [`SLC_SV_W-1:0] pin_sv;
	reg  [`SLC_SV_W-1:0] eff_sv;
	reg  [`SLC_DF_W-1:0] eff_df;
	reg  [`SLC_DF_W-1:0] cfg_q;
	reg  [`SLC_DF_W-1:0] cfg_d;
	reg  [2:0]           xo_q;
	reg  [2:0]           xo_d;
	wire                 capture;
	wire                 dig_req;
	wire                 reload_req;
	wire                 ldr_fin;
	wire                 reload_cfg;

	// bring all strap pins into the clock domain
	slc_sync #(
		.W (6 + HARD_W)
	) u_sync (
		.CLK (CLK),
		.D   ({STRAP_HARD, STRAP_SPEED, STRAP_AUTONEG, STRAP_AUTO_XOVER,
		       STRAP_LED_FUNCTION_BITS, STRAP_LED_SELECT_BITS}),
		.Q   (pins_sync)
	);

	// derived register defaults from a soft strap vector
	function [`SLC_DF_W-1:0] slc_defaults;
		input [`SLC_SV_W-1:0] sv;
		reg                   an;
		reg                   spd;
		reg                   dup;
		begin
			an  = sv[`SLC_SV_AN];
			spd = sv[`SLC_SV_SPD];
			dup = an ? 1'b1 : `SLC_TIE_DUPLEX;
			slc_defaults = {`SLC_DF_W{1'b0}};
			slc_defaults[`SLC_DF_LED_SEL+:8] = sv[`SLC_SV_LED_SEL+:8];
			slc_defaults[`SLC_DF_LED_FUNCTION_BITS+:2] = sv[`SLC_SV_LED_FUNCTION_BITS+:2];
			slc_defaults[`SLC_DF_AN]  = an;
			slc_defaults[`SLC_DF_SPD] = an ? 1'b1 : spd;
			slc_defaults[`SLC_DF_DUP] = dup;
			slc_defaults[`SLC_DF_ADV6] = an | (~spd & dup);
			slc_defaults[`SLC_DF_ADV5] = an | (~spd & ~dup);
			slc_defaults[`SLC_DF_MODE+:3] =
				an ? `SLC_MODE_AN : {1'b0, spd, dup};
		end
	endfunction

	// soft strap vector as seen on the pins, tie-offs filled in
	always @*
	begin
		pin_sv = {`SLC_SV_W{1'b0}};
		pin_sv[`SLC_SV_LED_SEL+:8] = {8{pins_sync[0]}};
		pin_sv[`SLC_SV_LED_FUNCTION_BITS+:2] = pins_sync[2:1];
		pin_sv[`SLC_SV_XAUTO]      = pins_sync[3];
		pin_sv[`SLC_SV_XMAN]       = `SLC_TIE_XMAN;
		pin_sv[`SLC_SV_AN]         = pins_sync[4];
		pin_sv[`SLC_SV_SPD]        = pins_sync[5];
	end

	// first cycle after chip reset release is the capture cycle
	assign capture = RST_N & ~up_q;

	always @(posedge CLK)
	begin
		if (!RST_N)
			up_q <= 1'b0;
		else
			up_q <= 1'b1;
	end

	// private strap storage, written only at chip reset release
	always @(posedge CLK)
	begin
		if (!RST_N)
		begin
			latched_q <= `SLC_SV_RESET;
			hard_q    <= {HARD_W{1'b0}};
		end
		else if (capture)
		begin
			latched_q <= pin_sv;
			hard_q    <= pins_sync[5+HARD_W:6];
		end
	end

	// hard straps pass straight out, the loader never touches them
	assign HARD_CFG = hard_q;

	// register strobes decoded
	assign dig_req    = WR & (ADDR == `SLC_OFF_RESET) &
	                    WDATA[`SLC_RST_DIGITAL];
	assign reload_req = WR & (ADDR == `SLC_OFF_EECMD) &
	                    WDATA[`SLC_CMD_RELOAD];
	assign ldr_fin    = LDR_DONE & busy_q;

	// loader start and busy tracking; a new start beats a finish
	always @(posedge CLK)
	begin
		if (!RST_N)
		begin
			LDR_START     <= 1'b0;
			DIGITAL_RESET <= 1'b0;
			busy_q        <= 1'b0;
		end
		else
		begin
			LDR_START     <= capture | dig_req | reload_req;
			DIGITAL_RESET <= dig_req;
			if (capture | dig_req | reload_req)
				busy_q <= 1'b1;
			else if (ldr_fin)
				busy_q <= 1'b0;
		end
	end

	// override layer above the latched storage
	always @(posedge CLK)
	begin
		if (!RST_N)
		begin
			ovr_q       <= `SLC_SV_RESET;
			ovr_valid_q <= 1'b0;
		end
		else if (ldr_fin)
		begin
			if (LDR_OK)
			begin
				ovr_q       <= LDR_DATA;
				ovr_valid_q <= 1'b1;
			end
			else
				ovr_valid_q <= 1'b0;
		end
	end

	// effective soft straps; pins never resampled here
	always @*
	begin
		if (capture)
			eff_sv = pin_sv;
		else if (ldr_fin)
			eff_sv = LDR_OK ? LDR_DATA : latched_q;
		else if (ovr_valid_q)
			eff_sv = ovr_q;
		else
			eff_sv = latched_q;
		eff_df = slc_defaults(eff_sv);
	end

	// registers take their defaults at capture, digital reset, load end
	assign reload_cfg = capture | dig_req | ldr_fin;

	// next value of the configuration registers
	always @*
	begin
		cfg_d = cfg_q;
		xo_d  = xo_q;
		if (reload_cfg)
		begin
			cfg_d = eff_df;
			xo_d  = {eff_sv[`SLC_SV_XMAN], eff_sv[`SLC_SV_XAUTO], 1'b0};
		end
		else if (WR)
		begin
			case (ADDR)
			`SLC_OFF_LEDCFG:
			begin
				cfg_d[`SLC_DF_LED_SEL+:8] = WDATA[`SLC_LED_SEL_LSB+:8];
				cfg_d[`SLC_DF_LED_FUNCTION_BITS+:2] = WDATA[`SLC_LED_FUNCTION_BITS_LSB+:2];
			end
			`SLC_OFF_PHYCTL:
			begin
				cfg_d[`SLC_DF_AN]  = WDATA[`SLC_AUTONEG_ENABLE_BIT];
				cfg_d[`SLC_DF_SPD] = WDATA[`SLC_PHY_SPD];
				cfg_d[`SLC_DF_DUP] = WDATA[`SLC_PHY_DUP];
			end
			`SLC_OFF_ADVERT:
			begin
				cfg_d[`SLC_DF_ADV6] = WDATA[`SLC_ADV_10FD];
				cfg_d[`SLC_DF_ADV5] = WDATA[`SLC_ADV_10HD];
			end
			`SLC_OFF_SPMODE:
				cfg_d[`SLC_DF_MODE+:3] = WDATA[2:0];
			`SLC_OFF_XOVER:
				xo_d = WDATA[2:0];
			default:
				cfg_d = cfg_q;
			endcase
		end
	end

	// configuration registers
	always @(posedge CLK)
	begin
		if (!RST_N)
		begin
			cfg_q <= {`SLC_DF_W{1'b0}};
			xo_q  <= 3'h0;
		end
		else
		begin
			cfg_q <= cfg_d;
			xo_q  <= xo_d;
		end
	end

	assign LED_SELECT   = cfg_q[`SLC_DF_LED_SEL+:8];
	assign LED_FUNCTION = cfg_q[`SLC_DF_LED_FUNCTION_BITS+:2];
	assign P1_AUTONEG   = cfg_q[`SLC_DF_AN];
	assign P1_SPEED_LOW = cfg_q[`SLC_DF_SPD];
	assign P1_DUPLEX    = cfg_q[`SLC_DF_DUP];
	assign P1_ADV_10FD  = cfg_q[`SLC_DF_ADV6];
	assign P1_ADV_10HD  = cfg_q[`SLC_DF_ADV5];
	assign P1_MODE      = cfg_q[`SLC_DF_MODE+:3];

	// crossover mode: straps unless software override is set
	always @(posedge CLK)
	begin
		if (!RST_N)
		begin
			P1_XOVER_AUTO  <= 1'b0;
			P1_XOVER_CROSS <= 1'b0;
		end
		else if (xo_q[`SLC_XO_OVR])
		begin
			P1_XOVER_AUTO  <= xo_q[`SLC_XO_AUTO];
			P1_XOVER_CROSS <= xo_q[`SLC_XO_MAN];
		end
		else
		begin
			P1_XOVER_AUTO  <= eff_sv[`SLC_SV_XAUTO];
			P1_XOVER_CROSS <= ~eff_sv[`SLC_SV_XAUTO] &
			                  eff_sv[`SLC_SV_XMAN];
		end
	end

	// read data, valid in the cycle after the read strobe
	always @(posedge CLK)
	begin
		if (!RST_N)
			RDATA <= 32'h0000_0000;
		else if (RD)
		begin
			RDATA <= 32'h0000_0000;
			case (ADDR)
			`SLC_OFF_EECMD:
			begin
				RDATA[`SLC_CMD_BUSY] <= busy_q;
				RDATA[`SLC_CMD_OVR]  <= ovr_valid_q;
			end
			`SLC_OFF_LEDCFG:
			begin
				RDATA[`SLC_LED_SEL_LSB+:8] <= cfg_q[`SLC_DF_LED_SEL+:8];
				RDATA[`SLC_LED_FUNCTION_BITS_LSB+:2] <= cfg_q[`SLC_DF_LED_FUNCTION_BITS+:2];
			end
			`SLC_OFF_PHYCTL:
			begin
				RDATA[`SLC_AUTONEG_ENABLE_BIT]  <= cfg_q[`SLC_DF_AN];
				RDATA[`SLC_PHY_SPD] <= cfg_q[`SLC_DF_SPD];
				RDATA[`SLC_PHY_DUP] <= cfg_q[`SLC_DF_DUP];
			end
			`SLC_OFF_ADVERT:
			begin
				RDATA[`SLC_ADV_10FD] <= cfg_q[`SLC_DF_ADV6];
				RDATA[`SLC_ADV_10HD] <= cfg_q[`SLC_DF_ADV5];
			end
			`SLC_OFF_SPMODE:
				RDATA[2:0] <= cfg_q[`SLC_DF_MODE+:3];
			`SLC_OFF_XOVER:
				RDATA[2:0] <= xo_q;
			`SLC_OFF_LATCHED:
				RDATA[`SLC_SV_W-1:0] <= latched_q;
			`SLC_OFF_HARD:
				RDATA[HARD_W-1:0] <= hard_q;
			default:
				RDATA <= 32'h0000_0000;
			endcase
		end
		else
			RDATA <= 32'h0000_0000;
	end

endmodule

// File: testbench/slc_loader_model.sv
/*
 * Behavioural loader on the far side of the strap block: answers a start
 * after a set wait, with good data or an absent-device result.
 * Assumes start is a one-cycle pulse on clk.
 */
`timescale 1ns/1ps
`include "slc_regs.vh"

module slc_loader_model (
	input  wire                 clk,
	input  wire                 rst_n,
	input  wire                 start,
	input  wire                 ok_cfg,
	input  wire [`SLC_SV_W-1:0] data_cfg,
	input  wire [3:0]           wait_cfg,
	output reg                  done,
	output reg                  ok,
	output reg  [`SLC_SV_W-1:0] data
);
	reg       busy_q;
	reg [3:0] cnt_q;

	// count down, answer one cycle; idle lines keep moving
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			busy_q <= 1'b0;
			cnt_q <= 4'h0;
			done <= 1'b0;
			ok <= 1'b0;
			data <= 14'h0000;
		end
		else
		begin
			done <= 1'b0;
			ok <= ~ok;
			data <= ~data;
			if (start)
			begin
				busy_q <= 1'b1;
				cnt_q <= wait_cfg;
			end
			else if (busy_q && cnt_q == 4'h0)
			begin
				busy_q <= 1'b0;
				done <= 1'b1;
				ok <= ok_cfg;
				data <= data_cfg;
			end
			else if (busy_q)
				cnt_q <= cnt_q - 4'h1;
		end
	end
endmodule

// File: testbench/slc_top_properties.sv
/*
 * Port checker for slc_top: capture defaults, loader start, bus answer.
 * Assumes strap pins held steady for some cycles around reset release.
 */
`timescale 1ns/1ps
`include "slc_regs.vh"

module slc_top_properties #(
	parameter HARD_W = 4
) (
	input wire              CLK,
	input wire              RST_N,
	input wire              STRAP_LED_SELECT_BITS,
	input wire [1:0]        STRAP_LED_FUNCTION_BITS,
	input wire              STRAP_AUTONEG,
	input wire              STRAP_SPEED,
	input wire [7:0]        ADDR,
	input wire [31:0]       WDATA,
	input wire              WR,
	input wire              RD,
	input wire [31:0]       RDATA,
	input wire              LDR_START,
	input wire              DIGITAL_RESET,
	input wire [HARD_W-1:0] HARD_CFG,
	input wire [7:0]        LED_SELECT,
	input wire [1:0]        LED_FUNCTION,
	input wire              P1_AUTONEG,
	input wire              P1_SPEED_LOW,
	input wire              P1_DUPLEX,
	input wire [2:0]        P1_MODE
);
	// one clock domain, chip reset disables all
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	property p_rdata_idle;
		!$past(RD) |-> RDATA == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("stray read data");
	property p_cap_start;
		$rose(RST_N) |=> LDR_START;
	endproperty
	a_cap_start: assert property (p_cap_start) else $error("no load at capture");
	property p_dig;
		WR && ADDR == `SLC_OFF_RESET && WDATA[0] |=> DIGITAL_RESET && LDR_START;
	endproperty
	a_dig: assert property (p_dig) else $error("digital reset not started");
	property p_start_pulse;
		LDR_START |=> !LDR_START;
	endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("start too long");
	property p_hard_hold;
		$past(RST_N) && $past(RST_N, 2) |-> $stable(HARD_CFG);
	endproperty
	a_hard_hold: assert property (p_hard_hold) else $error("hard straps moved");
	property p_led_cap;
		$past(RST_N) && !$past(RST_N, 2) |-> LED_SELECT ==
			{8{$past(STRAP_LED_SELECT_BITS, 2)}} && LED_FUNCTION == $past(STRAP_LED_FUNCTION_BITS, 2);
	endproperty
	a_led_cap: assert property (p_led_cap) else $error("led defaults wrong");
	property p_an_cap;
		$past(RST_N) && !$past(RST_N, 2) |-> P1_DUPLEX &&
			P1_AUTONEG == $past(STRAP_AUTONEG, 2);
	endproperty
	a_an_cap: assert property (p_an_cap) else $error("autoneg default wrong");
	property p_spd_cap;
		$past(RST_N) && !$past(RST_N, 2) |->
			P1_SPEED_LOW == ($past(STRAP_AUTONEG, 2) | $past(STRAP_SPEED, 2))
			&& P1_MODE == ($past(STRAP_AUTONEG, 2) ? 3'h7
			: {1'b0, $past(STRAP_SPEED, 2), 1'b1});
	endproperty
	a_spd_cap: assert property (p_spd_cap) else $error("speed default wrong");
endmodule

bind slc_top slc_top_properties #(.HARD_W(HARD_W)) slc_top_properties_i (
	.CLK, .RST_N, .STRAP_LED_SELECT_BITS, .STRAP_LED_FUNCTION_BITS, .STRAP_AUTONEG, .STRAP_SPEED,
	.ADDR, .WDATA, .WR, .RD, .RDATA, .LDR_START, .DIGITAL_RESET, .HARD_CFG,
	.LED_SELECT, .LED_FUNCTION, .P1_AUTONEG, .P1_SPEED_LOW, .P1_DUPLEX,
	.P1_MODE
);

// File: testbench/tb.sv
/*
 * Self-checking bench for slc_top: capture, loader override, restore on
 * digital reset and reload, crossover override, relatch on chip reset.
 * Assumes the loader model and the bound port checker.
 */
`timescale 1ns/1ps
`include "slc_regs.vh"

module tb;
	reg         clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ld_ok = 1'b0;
	reg         s_led = 1'b0, s_auto = 1'b0, s_an = 1'b0, s_spd = 1'b0;
	reg  [1:0]  s_fun = 2'h0;
	reg  [3:0]  s_hard = 4'h0, ld_wait = 4'h5;
	reg  [7:0]  addr = 8'h00;
	reg  [31:0] wdata = 32'h0;
	reg  [13:0] ld_data = 14'h0000;
	wire [31:0] rdata;
	wire [13:0] l_data;
	wire [7:0]  led_sel;
	wire [3:0]  hard_cfg;
	wire [2:0]  mode;
	wire [1:0]  led_function_bits;
	wire        l_start, l_done, l_ok, dig, an, spd, dup, fd, hd, xa, xc;
	integer     error_cnt = 0, comparisons = 0;

	// design and loader
	slc_top #(.HARD_W(4)) slc_top_i (.CLK(clk), .RST_N(rst_n),
		.STRAP_LED_SELECT_BITS(s_led), .STRAP_LED_FUNCTION_BITS(s_fun), .STRAP_AUTO_XOVER(s_auto),
		.STRAP_AUTONEG(s_an), .STRAP_SPEED(s_spd), .STRAP_HARD(s_hard),
		.ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.LDR_START(l_start), .LDR_DONE(l_done), .LDR_OK(l_ok),
		.LDR_DATA(l_data), .DIGITAL_RESET(dig), .HARD_CFG(hard_cfg),
		.LED_SELECT(led_sel), .LED_FUNCTION(led_function_bits), .P1_AUTONEG(an),
		.P1_SPEED_LOW(spd), .P1_DUPLEX(dup), .P1_ADV_10FD(fd), .P1_ADV_10HD(hd),
		.P1_MODE(mode), .P1_XOVER_AUTO(xa), .P1_XOVER_CROSS(xc));
	slc_loader_model slc_loader_model_i (.clk(clk), .rst_n(rst_n),
		.start(l_start), .ok_cfg(ld_ok), .data_cfg(ld_data),
		.wait_cfg(ld_wait), .done(l_done), .ok(l_ok), .data(l_data));

	// 200 MHz clock
	always #2.5 clk = ~clk;

	task chk(input [31:0] got, input [31:0] exp);
	begin
		comparisons = comparisons + 1;
		if (got !== exp)
		begin
			error_cnt = error_cnt + 1;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask

	task tally_and_finish;
	begin
		$display("errors=%0d comparisons=%0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask

	task bus(input w, input [7:0] a, input [31:0] d);
	begin
		@(posedge clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
	end
	endtask

	task rdc(input [7:0] a, input [31:0] e);
	begin
		bus(1'b0, a, 32'h0);
		chk(rdata, e);
	end
	endtask

	task wait_ldr;
	integer n;
	begin
		for (n = 0; l_done !== 1'b1 && n < 60; n = n + 1)
			@(negedge clk);
		if (n == 60)
		begin
			error_cnt = error_cnt + 1;
			tally_and_finish;
		end
		repeat (3) @(posedge clk);
		#1;
	end
	endtask

	task t_capture(input l, input [1:0] f, input au, a, s, input [3:0] h);
	begin
		@(posedge clk);
		rst_n <= 1'b0;
		{s_led, s_fun, s_auto, s_an, s_spd, s_hard} <= {l, f, au, a, s, h};
		ld_ok <= 1'b0;
		ld_wait <= 4'h5;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		wait_ldr;
		chk({led_sel, led_function_bits}, {{8{l}}, f});
		chk({an, spd, dup, fd, hd, mode},
			{a, a | s, 1'b1, a | !s, a, a ? 3'h7 : {1'b0, s, 1'b1}});
		chk({xa, xc, hard_cfg}, {au, 1'b0, h});
		rdc(`SLC_OFF_LATCHED, {s, a, 1'b0, au, f, {8{l}}});
		rdc(8'h40, 32'h0);
	end
	endtask

	task t_load;
	begin
		ld_ok <= 1'b1;
		ld_data <= 14'h195A;
		ld_wait <= 4'h0;
		{s_led, s_spd} <= ~{s_led, s_spd};
		bus(1'b1, `SLC_OFF_EECMD, 32'h1);
		wait_ldr;
		chk({led_sel, led_function_bits, an, spd, mode}, {8'h5A, 2'h1, 5'h1F});
		chk({fd, hd, xa, xc}, 4'hD);
		rdc(`SLC_OFF_EECMD, 32'h4);
		bus(1'b1, `SLC_OFF_HARD, 32'hF);
		rdc(`SLC_OFF_HARD, 32'hA);
	end
	endtask

	task t_restore(input [7:0] a);
	begin
		ld_ok <= 1'b0;
		ld_wait <= 4'h3;
		bus(1'b1, a, 32'h1);
		wait_ldr;
		chk({led_sel, led_function_bits, an, spd, xa, xc}, 14'h3FE6);
		rdc(`SLC_OFF_LATCHED, 32'h26FF);
		rdc(`SLC_OFF_EECMD, 32'h0);
	end
	endtask

	task t_xover;
	begin
		bus(1'b1, `SLC_OFF_XOVER, 32'h5);
		rdc(`SLC_OFF_XOVER, 32'h5);
		chk({xa, xc}, 2'h1);
		bus(1'b1, `SLC_OFF_XOVER, 32'h2);
		repeat (2) @(posedge clk);
		chk({xa, xc}, 2'h2);
	end
	endtask

	// main sequence
	initial
	begin
		repeat (2) @(posedge clk);
		t_capture(1'b1, 2'h2, 1'b1, 1'b0, 1'b1, 4'hA);
		t_load;
		t_restore(`SLC_OFF_RESET);
		t_xover;
		t_load;
		t_restore(`SLC_OFF_EECMD);
		t_capture(1'b0, 2'h1, 1'b0, 1'b1, 1'b0, 4'h5);
		tally_and_finish;
	end
endmodule
